// ==== src/ccr_gain_line.sv ====
// Delay line standing for the charge multiplying register.
`timescale 1ns/10ps
module ccr_gain_line #(
  parameter int unsigned STAGES = ccr_pkg::MULT_STAGES,  // Transfers along the register.
  parameter int unsigned W      = ccr_pkg::PIX_W         // Packet width.
) (
  input  wire logic         clock,     // System clock.
  input  wire logic         rst,       // Asynchronous reset, active high.
  input  wire logic         step,      // One multiplying transfer.
  input  wire logic         in_valid,  // Packet enters the register.
  input  wire logic [W-1:0] in_charge, // Charge entering.
  output logic              out_valid, // Packet leaves toward multiplier_out.
  output logic      [W-1:0] out_charge // Charge leaving.
);
  logic [W:0] stage_q [STAGES];

  // Each step moves every packet one stage; one step is one transfer, and a clock without step holds them.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < STAGES; i++) stage_q[i] <= '0;
    end else if (step) begin
      stage_q[0] <= {in_valid, in_charge};
      for (int i = 1; i < STAGES; i++) stage_q[i] <= stage_q[i-1];
    end
  end

  assign out_valid  = stage_q[STAGES-1][W];
  assign out_charge = stage_q[STAGES-1][W-1:0];
endmodule // ccr_gain_line

// ==== src/ccr_pkg.sv ====
// Package with constants and carrier types for the sensor charge routing model.
package ccr_pkg;
  localparam int unsigned DARK_ARRIVE_CYC  = 8;     // First dark column at the sense node.
  localparam int unsigned PHOTO_ARRIVE_CYC = 34;    // First photoactive packet at the sense node.
  localparam int unsigned ROUTE_DELAY_CYC  = 28;    // Sense to switch decision delay.
  localparam int unsigned MULT_STAGES      = 1800;  // Charge multiplying transfers.
  localparam int unsigned HPOS_W           = 12;    // Width of the line cycle counter.
  localparam int unsigned PIX_W            = 16;    // Width of a charge packet value.

  // Horizontal gate levels as seen by the sensor.
  typedef struct packed {
    logic phase_one;    // horiz_phase_one
    logic phase_two;    // horiz_phase_two
    logic store_two;    // horiz_store_two
    logic last_gate;    // horiz_last_gate
    logic float_exit;   // float_gate_exit
    logic float_reset;  // float_gate_reset
  } ccr_hgate_s;

  // Switch gates that steer one packet.
  typedef struct packed {
    logic low_gain;     // switch_low_gain_gate
    logic multiplier;   // switch_multiplier_gate
  } ccr_switch_s;

  // Packet leaving the block on one of the two outputs.
  typedef struct packed {
    logic             valid;
    logic [PIX_W-1:0] charge;
  } ccr_pkt_s;
endpackage

// ==== src/ccr_readout.sv ====
// Behavioural model of one sensor quadrant readout path and its charge switch.
//
// Behaviour
// - Each complementary horizontal cycle moves every packet one pixel toward outputs.
// - After row transfer, dark packet senses at cycle 8, photoactive at 34.
// - Falling last gate edge places packet under floating gate; sense follows size unless float_gate_reset is high at that edge, when sense is zero.
// - Multiplying register has 1800 transfers to multiplier_out.
`timescale 1ns/10ps
module ccr_readout #(
  parameter int unsigned COLS   = 64,                   // Packets held in one line.
  parameter int unsigned STAGES = ccr_pkg::MULT_STAGES, // Multiplying transfers.
  parameter int unsigned W      = ccr_pkg::PIX_W        // Packet width.
) (
  input  wire logic                 clock,         // System clock.
  input  wire logic                 rst,           // Asynchronous reset, active high.
  input  wire logic                 vert_phase1_top,    // Vertical phase one, top.
  input  wire logic                 vert_phase1_bottom, // Vertical phase one, bottom.
  input  wire logic                 row_transfer,  // Vertical row transfer in progress.
  input  wire logic [W-1:0]         row_fill,      // Charge each photoactive packet of a new row holds.
  input  wire ccr_pkg::ccr_hgate_s  hgate,         // Horizontal gate levels.
  input  wire ccr_pkg::ccr_switch_s sw,            // Charge switch gate levels.
  input  wire logic                 mult_clock,    // Multiplier stores and barriers cycle.
  output logic [W-1:0]              threshold_sense_out, // Floating gate sense level.
  output logic                      sense_valid,   // One-cycle pulse after a packet drops under the floating gate.
  output logic [ccr_pkg::HPOS_W-1:0] line_cycle,   // Horizontal cycles since row transfer.
  output logic                      photo_active,  // Sensed packet is photoactive.
  output ccr_pkg::ccr_pkt_s         low_gain_out,  // Packet on the low gain output.
  output ccr_pkg::ccr_pkt_s         multiplier_out // Packet on the multiplier output.
);
  ////////////////////////////////////////////////////////////////////////////
  logic [W-1:0]               col_q [COLS];
  logic [W-1:0]               pd_q;
  logic                       ph1_q;
  logic                       last_q;
  logic [W-1:0]               fg_q;
  logic                       fg_full_q;
  logic [W-1:0]               sense_q;
  logic                       sense_v_q;
  logic [ccr_pkg::HPOS_W-1:0] cyc_q;
  logic [W-1:0]               sw_q;
  logic                       sw_full_q;
  logic                       shift;
  logic                       last_fall;
  logic                       mult_v;
  logic [W-1:0]               mult_c;
  ccr_pkg::ccr_pkt_s          lg_q;
  ccr_pkg::ccr_pkt_s          mu_q;

  ////////////////////////////////////////////////////////////////////////////
  // Route that the two switch gates select for the packet waiting at the switch.
  typedef enum logic [1:0] {
    CCR_ROUTE_NONE,
    CCR_ROUTE_LOW,
    CCR_ROUTE_MULT
  } ccr_route_e;

  // True when a gate last sampled away from the wanted level now stands at it.
  function automatic logic gate_edge(input logic now_lvl, input logic prev_lvl,
                                     input logic to_high);
    gate_edge = (now_lvl == to_high) && (prev_lvl != to_high);
  endfunction

  // Exactly one switch gate high steers the packet; both or neither leave it waiting.
  function automatic ccr_route_e route_of(input ccr_pkg::ccr_switch_s gates);
    unique case ({gates.low_gain, gates.multiplier})
      2'h2:    route_of = CCR_ROUTE_LOW;
      2'h1:    route_of = CCR_ROUTE_MULT;
      default: route_of = CCR_ROUTE_NONE;
    endcase
  endfunction

  // Column idx is sensed on line cycle idx plus one, so it holds photodiode
  // charge when that cycle is the first photoactive one or later.
  function automatic logic photo_col(input int unsigned idx);
    photo_col = (idx + 32'h1) >= ccr_pkg::PHOTO_ARRIVE_CYC;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // A complementary cycle is the rising edge of phase one, with phase two low, outside a row transfer.
  assign shift     = gate_edge(hgate.phase_one, ph1_q, 1'b1) & ~row_transfer
                     & ~hgate.phase_two;
  assign last_fall = gate_edge(hgate.last_gate, last_q, 1'b0);

  // Phase one history resets to its parked high level, so reset shows no false edge.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph1_q <= 1'b1;
    end else begin
      ph1_q <= hgate.phase_one;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_q <= 1'b0;
    end else begin
      last_q <= hgate.last_gate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Photodiode charge is caught while vertical phase one is high at both top and bottom.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pd_q <= '0;
    end else if (vert_phase1_top & vert_phase1_bottom) begin
      pd_q <= row_fill;
    end
  end

  // Horizontal register: a row transfer loads it, each cycle shifts it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < COLS; i++) begin
        col_q[i] <= '0;
      end
    end else if (row_transfer) begin
      for (int i = 0; i < COLS; i++) begin
        col_q[i] <= photo_col(i) ? pd_q : '0;
      end
    end else if (shift) begin
      for (int i = 0; i < COLS - 1; i++) begin
        col_q[i] <= col_q[i+1];
      end
      col_q[COLS-1] <= '0;
    end
  end

  // Line cycle counter restarted by each row transfer.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cyc_q <= '0;
    end else if (row_transfer) begin
      cyc_q <= '0;
    end else if (shift && cyc_q != '1) begin
      cyc_q <= cyc_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The packet at the head waits under the last gate, then drops under the
  // floating gate on its falling edge; the exit pulse moves it onward.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fg_q      <= '0;
      fg_full_q <= 1'b0;
      sense_q   <= '0;
      sense_v_q <= 1'b0;
    end else begin
      sense_v_q <= last_fall;
      if (last_fall) begin
        fg_q      <= col_q[0];
        fg_full_q <= 1'b1;
        sense_q   <= hgate.float_reset ? '0 : col_q[0];
      end else if (hgate.float_exit & fg_full_q) begin
        fg_full_q <= 1'b0;
      end
    end
  end

  // Charge switch: the packet leaving the exit gate meets the switch gates.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sw_q      <= '0;
      sw_full_q <= 1'b0;
      lg_q      <= '0;
      mu_q      <= '0;
    end else begin
      lg_q.valid <= 1'b0;
      mu_q.valid <= 1'b0;
      if (hgate.float_exit & fg_full_q) begin
        sw_q      <= fg_q;
        sw_full_q <= 1'b1;
      end else if (sw_full_q) begin
        unique case (route_of(sw))
          CCR_ROUTE_LOW: begin
            lg_q      <= '{valid: 1'b1, charge: sw_q};
            sw_full_q <= 1'b0;
          end
          CCR_ROUTE_MULT: begin
            mu_q      <= '{valid: 1'b1, charge: sw_q};
            sw_full_q <= 1'b0;
          end
          CCR_ROUTE_NONE: begin
            sw_full_q <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  ccr_gain_line #(.STAGES(STAGES), .W(W)) u_gain (
    .clock     (clock),
    .rst       (rst),
    .step      (mult_clock),
    .in_valid  (mu_q.valid),
    .in_charge (mu_q.charge),
    .out_valid (mult_v),
    .out_charge(mult_c)
  );

  // The multiplier packet shows only on a step, the cycle in which it leaves.
  assign threshold_sense_out = sense_q;
  assign sense_valid         = sense_v_q;
  assign line_cycle          = cyc_q;
  assign photo_active        = cyc_q >= ccr_pkg::HPOS_W'(ccr_pkg::PHOTO_ARRIVE_CYC);
  assign low_gain_out        = lg_q;
  assign multiplier_out      = '{valid: mult_v & mult_clock, charge: mult_c};
endmodule // ccr_readout

// ==== test/ccr_ctrl_model.sv ====
// Camera timing generator model that clocks one pixel per request.
`timescale 1ns/10ps
module ccr_ctrl_model #(
  parameter logic [15:0] THRESH = 16'h007E // Decision level.
) (
  input  wire logic            clock,   // Clock.
  input  wire logic            rst,     // Reset.
  input  wire logic            go,      // Start one pixel.
  input  wire logic            mult_ok, // Multiplier route allowed.
  input  wire logic [15:0]     sense,   // Sensed level.
  output ccr_pkg::ccr_hgate_s  hgate,   // Horizontal gates.
  output ccr_pkg::ccr_switch_s sw,      // Switch gates.
  output logic                 busy     // Pattern running.
);
  // Last wait count; the exit and switch steps take one cycle each and the count starts at zero.
  localparam logic [4:0] WAIT_LAST = 5'(ccr_pkg::ROUTE_DELAY_CYC - 3);
  logic [2:0] st_q;
  logic [4:0] wait_q;
  logic       mult;
  assign busy = st_q != 3'h0;
  assign mult = mult_ok && sense < THRESH;
  // Step 5 waits after the exit so the switch acts 28 cycles after sensing.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= 3'h0;
    end else if (st_q == 3'h3) begin
      st_q <= 3'h5;
    end else if (st_q == 3'h5) begin
      st_q <= (wait_q == WAIT_LAST) ? 3'h4 : 3'h5;
    end else if (busy || go) begin
      st_q <= (st_q == 3'h4) ? 3'h0 : st_q + 3'h1;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_q <= 5'h00;
    end else begin
      wait_q <= (st_q == 3'h5) ? wait_q + 5'h01 : 5'h00;
    end
  end
  // Idle parks phase one high; step 2 shifts and drops the last gate together.
  always_comb begin
    hgate.phase_one   = st_q != 3'h1;
    hgate.phase_two   = st_q == 3'h1;
    hgate.store_two   = st_q == 3'h1;
    hgate.last_gate   = st_q == 3'h1;
    hgate.float_exit  = st_q == 3'h3;
    hgate.float_reset = st_q == 3'h3;
    sw.low_gain       = st_q == 3'h4 && !mult;
    sw.multiplier     = st_q == 3'h4 && mult;
  end
endmodule // ccr_ctrl_model

// ==== test/ccr_readout_sva.sv ====
// Checker for the charge routing readout ports.
`timescale 1ns/10ps
module ccr_readout_sva #(
  parameter int unsigned W = 16 // Packet width.
) (
  input wire logic                      clock,          // Clock.
  input wire logic                      rst,            // Reset.
  input wire logic                      row_transfer,   // Row transfer.
  input wire ccr_pkg::ccr_hgate_s       hgate,          // Horizontal gates.
  input wire ccr_pkg::ccr_switch_s      sw,             // Switch gates.
  input wire logic                      mult_clock,     // Multiplier cycle.
  input wire logic [W-1:0]              threshold_sense_out, // Sense level.
  input wire logic                      sense_valid,    // Sense pulse.
  input wire logic [ccr_pkg::HPOS_W-1:0] line_cycle,    // Line cycles.
  input wire logic                      photo_active,   // Photoactive flag.
  input wire ccr_pkg::ccr_pkt_s         low_gain_out,   // Low gain packet.
  input wire ccr_pkg::ccr_pkt_s         multiplier_out  // Multiplier packet.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_sense_follows: assert property ($fell(hgate.last_gate) |=> sense_valid)
    else $error("sense pulse missing");
  a_sense_cause: assert property (sense_valid |-> $past(hgate.last_gate, 2) && !$past(hgate.last_gate))
    else $error("sense pulse without gate fall");
  a_sense_stands: assert property (!$fell(hgate.last_gate) |=> $stable(threshold_sense_out))
    else $error("sense level changed");
  a_row_zeroes: assert property (row_transfer |=> line_cycle == '0)
    else $error("line counter not cleared");
  a_shift_counts: assert property ($rose(hgate.phase_one) && !hgate.phase_two && !row_transfer
    && line_cycle != '1 |=> line_cycle == $past(line_cycle) + 1'b1)
    else $error("shift not counted");
  a_idle_holds: assert property (!$rose(hgate.phase_one) && !row_transfer |=> $stable(line_cycle))
    else $error("line counter moved");
  a_photo_flag: assert property (photo_active == (line_cycle >= 12'h022))
    else $error("photoactive flag wrong");
  a_low_route: assert property (low_gain_out.valid |-> $past(sw.low_gain) && !$past(sw.multiplier))
    else $error("low gain packet without switch");
  a_mult_step: assert property (!mult_clock |=> $stable(multiplier_out.charge))
    else $error("multiplier packet moved without step");
  c_photo: cover property (photo_active);
  c_low: cover property (low_gain_out.valid);
  c_mult: cover property (multiplier_out.valid);
endmodule // ccr_readout_sva
bind ccr_readout ccr_readout_sva #(.W(W)) u_sva (.clock(clock), .rst(rst),
  .row_transfer(row_transfer), .hgate(hgate), .sw(sw), .mult_clock(mult_clock),
  .threshold_sense_out(threshold_sense_out), .sense_valid(sense_valid),
  .line_cycle(line_cycle), .photo_active(photo_active), .low_gain_out(low_gain_out),
  .multiplier_out(multiplier_out));

// ==== test/ccr_readout_tb.sv ====
// Testbench for the charge routing readout.
`timescale 1ns/10ps
module ccr_readout_tb;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 vert_on = 1'b0;
  logic                 row_transfer = 1'b0;
  logic                 go = 1'b0;
  logic                 mult_ok = 1'b0;
  logic                 mult_clock = 1'b0;
  logic [15:0]          row_fill = 16'h0000;
  logic [15:0]          sense;
  logic [11:0]          line_cycle;
  logic                 sense_valid;
  logic                 photo_active;
  logic                 busy;
  ccr_pkg::ccr_hgate_s  hgate;
  ccr_pkg::ccr_switch_s sw;
  ccr_pkg::ccr_pkt_s    low_gain_out;
  ccr_pkg::ccr_pkt_s    multiplier_out;
  int                   errors = 0;
  int                   n_tests = 0;
  int                   n;
  always #12.5 clock = ~clock;
  ccr_readout #(.STAGES(8)) uut (.clock(clock), .rst(rst), .vert_phase1_top(vert_on),
    .vert_phase1_bottom(vert_on), .row_transfer(row_transfer), .row_fill(row_fill),
    .hgate(hgate), .sw(sw), .mult_clock(mult_clock), .threshold_sense_out(sense),
    .sense_valid(sense_valid), .line_cycle(line_cycle), .photo_active(photo_active),
    .low_gain_out(low_gain_out), .multiplier_out(multiplier_out));
  ccr_ctrl_model model (.clock(clock), .rst(rst), .go(go), .mult_ok(mult_ok),
    .sense(sense), .hgate(hgate), .sw(sw), .busy(busy));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic load_row(input logic [15:0] fill);
    row_fill = fill;
    vert_on = 1'b1;
    repeat (40) @(negedge clock);
    vert_on = 1'b0;
    row_transfer = 1'b1;
    @(negedge clock);
    row_transfer = 1'b0;
    check("line_cycle", {4'h0, line_cycle}, 16'h0000);
  endtask
  task automatic pixel(input int idx, input logic [15:0] fill, input logic mult);
    int k;
    logic [15:0] exp;
    logic to_low;
    exp = (idx >= 34) ? fill : 16'h0000;
    to_low = !(mult && exp < 16'h007E);
    mult_ok = mult;
    go = 1'b1;
    @(negedge clock);
    go = 1'b0;
    for (k = 0; k < 40 && busy; k++) @(negedge clock);
    if (busy) begin
      errors++;
      test_done();
    end
    check("line_cycle", {4'h0, line_cycle}, idx[15:0]);
    check("photo_active", {15'h0, photo_active}, {15'h0, idx >= 34});
    check("sense", sense, exp);
    check("low_valid", {15'h0, low_gain_out.valid}, {15'h0, to_low});
    if (to_low) check("low_charge", low_gain_out.charge, exp);
  endtask
  task automatic mult_route(input logic [15:0] fill);
    int k;
    load_row(fill);
    mult_clock = 1'b1;
    for (k = 1; k <= 35; k++) pixel(k, fill, k == 35);
    for (k = 0; k < 40 && multiplier_out.valid !== 1'b1; k++) @(negedge clock);
    check("mult_valid", {15'h0, multiplier_out.valid}, {15'h0, fill < 16'h007E});
    if (fill < 16'h007E) check("mult_charge", multiplier_out.charge, fill);
    mult_clock = 1'b0;
  endtask
  initial begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check("reset_low", {15'h0, low_gain_out.valid}, 16'h0000);
    load_row(16'h1234);
    for (n = 1; n <= 36; n++) pixel(n, 16'h1234, 1'b0);
    mult_route(16'h007D);
    mult_route(16'h007E);
    test_done();
  end
endmodule // ccr_readout_tb
